/* File: shared/ces_pkg.sv */
// Constants and types shared by the exception sequencer files.
package ces_pkg;
	// Source counts per requester group.
	localparam int CES_N_EXT = 8;
	localparam int CES_N_DMA = 4;
	localparam int CES_N_TMR = 15;
	localparam int CES_N_SER = 8;
	localparam int CES_N_WDT = 1;
	localparam int CES_N_BSC = 2;
	localparam int CES_N_CHIP = CES_N_DMA + CES_N_TMR + CES_N_SER + CES_N_WDT + CES_N_BSC;
	localparam int CES_N_SRC = 2 + CES_N_EXT + CES_N_CHIP;
	// Arbiter source indices.
	localparam logic [5:0] CES_IDX_NMI = 6'h00;
	localparam logic [5:0] CES_IDX_BRK = 6'h01;
	localparam logic [5:0] CES_IDX_EXT = 6'h02;
	localparam logic [5:0] CES_IDX_CHIP = 6'h0A;
	// Fixed priority levels and the mask loaded for the nonmaskable source.
	localparam logic [4:0] CES_LVL_NMI = 5'h10;
	localparam logic [4:0] CES_LVL_BRK = 5'h0F;
	localparam logic [3:0] CES_MASK_NMI = 4'hF;
	// Vector numbers of the interrupt sources.
	localparam logic [7:0] CES_VEC_NMI = 8'h0B;
	localparam logic [7:0] CES_VEC_BRK = 8'h0C;
	localparam logic [7:0] CES_VEC_EXT = 8'h40;
	localparam logic [7:0] CES_VEC_CHIP = 8'h48;
	// Stack step and vector entry scaling.
	localparam logic [31:0] CES_STACK_STEP = 32'h0000_0004;
	localparam int CES_VEC_SHIFT = 2;
	// Reset values of held state.
	localparam logic [31:0] CES_RST_WORD = 32'h0000_0000;
	localparam logic [7:0] CES_RST_VEC = 8'h00;
	localparam logic [3:0] CES_RST_MASK = 4'h0;
	localparam logic [5:0] CES_RST_IDX = 6'h00;
	// Instruction classes reported by the decoder.
	typedef enum logic [3:0] {
		CES_OP_OTHER,
		CES_OP_REGISTER_JUMP,
		CES_OP_SUBROUTINE_JUMP,
		CES_OP_RELATIVE_BRANCH,
		CES_OP_RELATIVE_CALL,
		CES_OP_SUBROUTINE_RETURN,
		CES_OP_EXCEPTION_RETURN,
		CES_OP_BRANCH_IF_SET,
		CES_OP_BRANCH_IF_CLEAR,
		CES_OP_SOFTWARE_TRAP,
		CES_OP_CONTROL_LDST,
		CES_OP_UNDEFINED
	} ces_op_t;
	// Sequencer states.
	typedef enum logic [2:0] {
		CES_IDLE,
		CES_PUSH_STATUS,
		CES_PUSH_PC,
		CES_FETCH
	} ces_state_t;
	// Kind of exception being processed.
	typedef enum logic [2:0] {
		CES_K_ADDR,
		CES_K_INT,
		CES_K_SLOT,
		CES_K_ILLEGAL,
		CES_K_TRAP
	} ces_kind_t;
endpackage

/* File: core/ces_arbiter.sv */
// Priority arbiter that picks the highest ranked pending interrupt source.
`timescale 1ns/1ns
`default_nettype none
module ces_arbiter
	import ces_pkg::*;
(
	// Requests.
	input wire logic nmi_req,
	input wire logic brk_req,
	input wire logic [CES_N_EXT-1:0] ext_req,
	input wire logic [CES_N_CHIP-1:0] chip_req,
	// Programmed levels, four bits per source.
	input wire logic [4*CES_N_EXT-1:0] ext_level,
	input wire logic [4*CES_N_CHIP-1:0] chip_level,
	// Winner.
	output logic win_valid,
	output logic [4:0] win_level,
	output logic [5:0] win_index,
	output logic [7:0] win_vector
);
	// Maps a source index onto its vector number.
	function automatic logic [7:0] vec_of(input logic [5:0] idx);
		if (idx == CES_IDX_NMI) begin
			return CES_VEC_NMI;
		end else if (idx == CES_IDX_BRK) begin
			return CES_VEC_BRK;
		end else if (idx < CES_IDX_CHIP) begin
			return CES_VEC_EXT + {2'h0, idx - CES_IDX_EXT};
		end
		return CES_VEC_CHIP + {2'h0, idx - CES_IDX_CHIP};
	endfunction

	// Scans all sources; a strictly higher level replaces the winner, so ties go
	// to the lower index and a level of zero never wins.
	always_comb begin
		win_level = 5'h00;
		win_index = CES_RST_IDX;
		if (nmi_req) begin
			win_level = CES_LVL_NMI;
			win_index = CES_IDX_NMI;
		end
		if (brk_req && CES_LVL_BRK > win_level) begin
			win_level = CES_LVL_BRK;
			win_index = CES_IDX_BRK;
		end
		for (int i = 0; i < CES_N_EXT; i++) begin
			if (ext_req[i] && {1'b0, ext_level[4*i +: 4]} > win_level) begin
				win_level = {1'b0, ext_level[4*i +: 4]};
				win_index = CES_IDX_EXT + 6'(i);
			end
		end
		for (int i = 0; i < CES_N_CHIP; i++) begin
			if (chip_req[i] && {1'b0, chip_level[4*i +: 4]} > win_level) begin
				win_level = {1'b0, chip_level[4*i +: 4]};
				win_index = CES_IDX_CHIP + 6'(i);
			end
		end
		win_valid = (win_level != 5'h00);
		win_vector = vec_of(win_index);
	end
endmodule
`default_nettype wire

/* File: core/ces_sequencer.sv */
// Exception sequencer: acceptance, stacking and vector fetch for exceptions.
//
// Function
// - address error waits for bus and execution
// - address error pushes status, decoded PC, vectors
// - forty interrupt sources across all groups
// - nonmaskable level sixteen accepted at any mask
// - break request has fixed level fifteen
// - line and peripheral levels programmable 0-15
// - highest pending priority wins arbitration
// - maskable level must exceed mask field
// - push status and PC, load level
// - nonmaskable loads mask fifteen, not sixteen
// - handler address from source vector entry
// - trap pushes status, next PC, vectors
// - undefined code in slot raises slot exception
// - PC-changing op in slot raises slot exception
// - slot exception stacks preceding branch target
// - undefined code elsewhere stacks its own address
// - six delayed branch classes have slots
// - no address error or interrupt in slot; disable holds interrupts
// - held exception taken at next allowed decode
// - vector entry is base plus four times number
// - each push predecrements stack pointer by four
// - control register moves hold off next interrupt
`timescale 1ns/1ns
`default_nettype none
module ces_sequencer
	import ces_pkg::*;
#(
	parameter logic [7:0] VEC_ADDR_ERR = 8'h09,
	parameter logic [7:0] VEC_SLOT = 8'h06,
	parameter logic [7:0] VEC_ILLEGAL = 8'h04
)(
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET,
	// Decoder.
	input wire logic DEC_VALID,
	input wire ces_op_t DEC_OP,
	input wire logic [31:0] DEC_PC,
	input wire logic [31:0] DEC_NEXT_PC,
	input wire logic [31:0] DEC_TARGET,
	input wire logic [7:0] DEC_TRAP_VEC,
	// Core state.
	input wire logic [31:0] STATUS_WORD,
	input wire logic [3:0] STATUS_MASK,
	input wire logic [31:0] STACK_PTR,
	input wire logic [31:0] VECTOR_BASE,
	// Address fault reporting.
	input wire logic ADDR_ERR,
	input wire logic BUS_BUSY,
	input wire logic EXEC_BUSY,
	// Interrupt requests.
	input wire logic NMI_REQ,
	input wire logic BRK_REQ,
	input wire logic [CES_N_EXT-1:0] EXT_REQ,
	input wire logic [4*CES_N_EXT-1:0] EXT_LEVEL,
	input wire logic [CES_N_CHIP-1:0] CHIP_REQ,
	input wire logic [4*CES_N_CHIP-1:0] CHIP_LEVEL,
	// Memory bus.
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [31:0] MEM_ADDR,
	output logic [31:0] MEM_WDATA,
	input wire logic [31:0] MEM_RDATA,
	input wire logic MEM_DONE,
	// Core updates.
	output logic EXC_BUSY,
	output logic INT_ACK,
	output logic [5:0] INT_ACK_INDEX,
	output logic SP_LOAD,
	output logic [31:0] SP_VALUE,
	output logic MASK_LOAD,
	output logic [3:0] MASK_VALUE,
	output logic PC_LOAD,
	output logic [31:0] PC_VALUE
);
	// Whole state of the sequencer.
	typedef struct packed {
		ces_state_t state;
		ces_kind_t kind;
		logic ae_pend;
		logic in_slot;
		logic int_hold;
		logic [31:0] slot_target;
		logic [31:0] sp;
		logic [31:0] save_pc;
		logic [7:0] vec;
		logic [3:0] new_mask;
		logic mask_upd;
		logic busy;
		logic int_ack;
		logic [5:0] ack_idx;
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic sp_load;
		logic mask_load;
		logic pc_load;
		logic [31:0] pc_value;
	} ces_state_s_t;

	ces_state_s_t s; // Registered state.
	ces_state_s_t next_s; // Next state.

	// Arbiter winner.
	logic win_valid;
	logic [4:0] win_level;
	logic [5:0] win_index;
	logic [7:0] win_vector;

	// Acceptance terms of the current decode.
	logic ae_ok;
	logic int_ok;
	logic slot_bad;

	// True for the classes that own a delay slot.
	function automatic logic is_delayed(input ces_op_t op);
		return op inside {CES_OP_REGISTER_JUMP, CES_OP_SUBROUTINE_JUMP,
			CES_OP_RELATIVE_BRANCH, CES_OP_RELATIVE_CALL,
			CES_OP_SUBROUTINE_RETURN, CES_OP_EXCEPTION_RETURN};
	endfunction

	// True for every class that rewrites the program counter.
	function automatic logic is_pc_mod(input ces_op_t op);
		return is_delayed(op) || op inside {CES_OP_BRANCH_IF_SET,
			CES_OP_BRANCH_IF_CLEAR, CES_OP_SOFTWARE_TRAP};
	endfunction

	// Source ranking over all groups.
	// all sources ranked
	ces_arbiter u_arbiter (
		.nmi_req(NMI_REQ),
		.brk_req(BRK_REQ),
		.ext_req(EXT_REQ),
		.chip_req(CHIP_REQ),
		.ext_level(EXT_LEVEL),
		.chip_level(CHIP_LEVEL),
		.win_valid(win_valid),
		.win_level(win_level),
		.win_index(win_index),
		.win_vector(win_vector)
	);

	// Acceptance conditions at a decode point.
	always_comb begin
		ae_ok = s.ae_pend && !BUS_BUSY && !EXEC_BUSY && !s.in_slot;
		int_ok = win_valid && !s.in_slot && !s.int_hold &&
			(win_index == CES_IDX_NMI || win_level > {1'b0, STATUS_MASK});
		slot_bad = s.in_slot && (DEC_OP == CES_OP_UNDEFINED || is_pc_mod(DEC_OP));
	end

	// Next-state logic of the sequencer.
	always_comb begin
		next_s = s;
		next_s.int_ack = 1'b0;
		next_s.sp_load = 1'b0;
		next_s.mask_load = 1'b0;
		next_s.pc_load = 1'b0;
		// Address faults are remembered; a fault in the stacking of an address
		// error is dropped so that faults cannot chain without end.
		if (ADDR_ERR && !(s.busy && s.kind == CES_K_ADDR)) begin
			next_s.ae_pend = 1'b1;
		end
		case (s.state)
			CES_IDLE: begin
				if (DEC_VALID) begin
					next_s.mask_upd = 1'b0;
					next_s.save_pc = DEC_PC;
					if (ae_ok) begin
						next_s.kind = CES_K_ADDR;
						next_s.vec = VEC_ADDR_ERR;
						if (!ADDR_ERR) begin
							next_s.ae_pend = 1'b0;
						end
					end else if (int_ok) begin
						next_s.kind = CES_K_INT;
						next_s.vec = win_vector;
						next_s.mask_upd = 1'b1;
						next_s.int_ack = 1'b1;
						next_s.ack_idx = win_index;
						next_s.new_mask = (win_index == CES_IDX_NMI) ? CES_MASK_NMI :
							win_level[3:0];
					end else if (slot_bad) begin
						next_s.kind = CES_K_SLOT;
						next_s.vec = VEC_SLOT;
						next_s.save_pc = s.slot_target;
					end else if (DEC_OP == CES_OP_UNDEFINED) begin
						next_s.kind = CES_K_ILLEGAL;
						next_s.vec = VEC_ILLEGAL;
					end else if (DEC_OP == CES_OP_SOFTWARE_TRAP) begin
						next_s.kind = CES_K_TRAP;
						next_s.vec = DEC_TRAP_VEC;
						next_s.save_pc = DEC_NEXT_PC;
					end
					if (ae_ok || int_ok || slot_bad || DEC_OP == CES_OP_UNDEFINED ||
						DEC_OP == CES_OP_SOFTWARE_TRAP) begin
						// First push: status word below the incoming pointer.
						// predecrement by four
						next_s.state = CES_PUSH_STATUS;
						next_s.busy = 1'b1;
						next_s.sp = STACK_PTR - CES_STACK_STEP;
						next_s.sp_load = 1'b1;
						next_s.mem_req = 1'b1;
						next_s.mem_we = 1'b1;
						next_s.mem_addr = STACK_PTR - CES_STACK_STEP;
						next_s.mem_wdata = STATUS_WORD;
						next_s.in_slot = 1'b0;
						next_s.int_hold = 1'b0;
					end else begin
						// The instruction proceeds; note what it means for the next one.
						// delayed class opens slot
						next_s.in_slot = is_delayed(DEC_OP);
						next_s.int_hold = (DEC_OP == CES_OP_CONTROL_LDST);
						if (is_delayed(DEC_OP)) begin
							next_s.slot_target = DEC_TARGET;
						end
					end
				end
			end
			CES_PUSH_STATUS: begin
				if (MEM_DONE && s.mem_req) begin
					// Second push: program counter.
					// second predecrement
					next_s.state = CES_PUSH_PC;
					next_s.sp = s.sp - CES_STACK_STEP;
					next_s.sp_load = 1'b1;
					next_s.mem_addr = s.sp - CES_STACK_STEP;
					next_s.mem_wdata = s.save_pc;
				end
			end
			CES_PUSH_PC: begin
				if (MEM_DONE && s.mem_req) begin
					// Vector entry read.
					// base plus four times number
					next_s.state = CES_FETCH;
					next_s.mem_we = 1'b0;
					next_s.mem_addr = VECTOR_BASE + {22'h0, s.vec, 2'h0};
				end
			end
			CES_FETCH: begin
				if (MEM_DONE && s.mem_req) begin
					// Jump straight to the handler; no delay slot follows.
					// non-delayed jump
					next_s.state = CES_IDLE;
					next_s.busy = 1'b0;
					next_s.mem_req = 1'b0;
					next_s.pc_load = 1'b1;
					next_s.pc_value = MEM_RDATA;
					next_s.mask_load = s.mask_upd;
				end
			end
			default: begin
				next_s.state = CES_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			s <= '{state: CES_IDLE, kind: CES_K_ADDR, ae_pend: 1'b0, in_slot: 1'b0,
				int_hold: 1'b0, slot_target: CES_RST_WORD, sp: CES_RST_WORD,
				save_pc: CES_RST_WORD, vec: CES_RST_VEC,
				new_mask: CES_RST_MASK, mask_upd: 1'b0, busy: 1'b0, int_ack: 1'b0,
				ack_idx: CES_RST_IDX, mem_req: 1'b0, mem_we: 1'b0,
				mem_addr: CES_RST_WORD, mem_wdata: CES_RST_WORD, sp_load: 1'b0,
				mask_load: 1'b0, pc_load: 1'b0, pc_value: CES_RST_WORD};
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register.
	assign MEM_REQ = s.mem_req;
	assign MEM_WE = s.mem_we;
	assign MEM_ADDR = s.mem_addr;
	assign MEM_WDATA = s.mem_wdata;
	assign EXC_BUSY = s.busy;
	assign INT_ACK = s.int_ack;
	assign INT_ACK_INDEX = s.ack_idx;
	assign SP_LOAD = s.sp_load;
	assign SP_VALUE = s.sp;
	assign MASK_LOAD = s.mask_load;
	assign MASK_VALUE = s.new_mask;
	assign PC_LOAD = s.pc_load;
	assign PC_VALUE = s.pc_value;

	// Checks on the sequencer.
	default clocking ces_cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	// Address error entry only after the bus and execution went quiet.
	AST_AE_WAIT: assert property (
		$rose(s.busy) && s.kind == CES_K_ADDR |-> $past(!BUS_BUSY && !EXEC_BUSY))
		else $error("Address error taken while bus or execution busy.");
	// The first write of every entry is the status word.
	AST_PUSH_STATUS_FIRST: assert property (
		$rose(s.busy) |-> s.mem_we && s.mem_req && s.mem_wdata == $past(STATUS_WORD))
		else $error("Entry did not start with a status word push.");
	// Program counter push sits four below the status word push.
	AST_SP_STEP: assert property (
		s.state == CES_PUSH_PC && $past(s.state) == CES_PUSH_STATUS |->
		s.mem_addr == $past(s.mem_addr) - CES_STACK_STEP && s.mem_wdata == s.save_pc)
		else $error("Stack pointer not decremented by four.");
	// Vector read address.
	AST_VEC_ADDR: assert property (
		s.state == CES_FETCH && $past(s.state) == CES_PUSH_PC |->
		!s.mem_we && s.mem_addr == $past(VECTOR_BASE) + {22'h0, s.vec, 2'h0})
		else $error("Vector entry address wrong.");
	// Nonmaskable entry loads mask fifteen.
	AST_NMI_MASK: assert property (
		s.mask_load && s.ack_idx == CES_IDX_NMI |-> s.new_mask == CES_MASK_NMI)
		else $error("Nonmaskable entry loaded wrong mask.");
	// Maskable interrupts exceed the mask.
	AST_MASK_GT: assert property (
		$rose(s.busy) && s.kind == CES_K_INT && s.ack_idx != CES_IDX_NMI |->
		s.new_mask > $past(STATUS_MASK))
		else $error("Interrupt accepted at or below mask.");
	// No address error or interrupt in a delay slot.
	AST_SLOT_BLOCK: assert property (
		$rose(s.busy) && s.kind inside {CES_K_ADDR, CES_K_INT} |-> !$past(s.in_slot))
		else $error("Exception taken in a delay slot.");
	// No interrupt right after a control register move.
	AST_HOLD_INT: assert property (
		$rose(s.busy) && s.kind == CES_K_INT |-> !$past(s.int_hold))
		else $error("Interrupt taken after a control register move.");
	// Slot exception stacks the branch target.
	AST_SLOT_PC: assert property (
		$rose(s.busy) && s.kind == CES_K_SLOT |-> s.save_pc == $past(s.slot_target))
		else $error("Slot exception stacked wrong address.");
	// A ready address error beats an interrupt.
	AST_AE_FIRST: assert property (
		$rose(s.busy) && s.kind == CES_K_INT |->
		!$past(s.ae_pend && !BUS_BUSY && !EXEC_BUSY))
		else $error("Interrupt taken ahead of address error.");

	// Main scenarios.
	COV_INT: cover property ($rose(s.busy) && s.kind == CES_K_INT);
	COV_ADDR: cover property ($rose(s.busy) && s.kind == CES_K_ADDR);
	COV_SLOT: cover property ($rose(s.busy) && s.kind == CES_K_SLOT);
	COV_TRAP: cover property (s.pc_load ##0 s.kind == CES_K_TRAP);
endmodule
`default_nettype wire

/* File: verif/ces_mem_model.sv */
// Memory responder for the stacking writes and vector reads of the sequencer.
`timescale 1ns/1ns
`default_nettype none
module ces_mem_model (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET,
	// Bus from the sequencer.
	input wire logic MEM_REQ,
	input wire logic MEM_WE,
	input wire logic [31:0] MEM_ADDR,
	input wire logic [31:0] MEM_WDATA,
	output logic [31:0] MEM_RDATA,
	output logic MEM_DONE,
	// Wait states per cycle, and the last three cycles, newest at index 2.
	input wire logic [3:0] wait_cycles,
	output logic [64:0] log_q [3]
);
	logic [3:0] cnt; // Wait states spent on the current cycle.
	// Read data is valid only with DONE; otherwise it toggles so stale data never matches.
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			cnt <= 4'h0;
			MEM_DONE <= 1'b0;
			MEM_RDATA <= 32'h0;
			log_q <= '{default: '0};
		end else if (MEM_DONE) begin
			MEM_DONE <= 1'b0;
			cnt <= 4'h0;
			MEM_RDATA <= ~MEM_RDATA;
		end else if (MEM_REQ && cnt == wait_cycles) begin
			MEM_DONE <= 1'b1;
			MEM_RDATA <= MEM_WE ? ~MEM_RDATA : MEM_ADDR ^ 32'hA5A5_0000;
			log_q[0] <= log_q[1];
			log_q[1] <= log_q[2];
			log_q[2] <= {MEM_WE, MEM_ADDR, MEM_WE ? MEM_WDATA : 32'h0};
		end else begin
			cnt <= MEM_REQ ? cnt + 4'h1 : 4'h0;
			MEM_RDATA <= ~MEM_RDATA;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the exception sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import ces_pkg::*;
	localparam logic [31:0] SP = 32'h0000_1000;
	localparam logic [31:0] BASE_INIT = 32'h0000_0400;
	localparam logic [31:0] STATUS_INIT = 32'h0000_00F0;
	logic CLOCK, RESET, DEC_VALID, ADDR_ERR, BUS_BUSY, EXEC_BUSY, NMI_REQ, BRK_REQ;
	logic MEM_REQ, MEM_WE, MEM_DONE, EXC_BUSY, INT_ACK, SP_LOAD, MASK_LOAD, PC_LOAD;
	ces_op_t DEC_OP;
	logic [31:0] DEC_PC, DEC_NEXT_PC, DEC_TARGET, STATUS_WORD, STACK_PTR, VECTOR_BASE;
	logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, SP_VALUE, PC_VALUE, EXT_LEVEL;
	logic [7:0] DEC_TRAP_VEC, EXT_REQ;
	logic [3:0] STATUS_MASK, MASK_VALUE, wait_cycles;
	logic [5:0] INT_ACK_INDEX;
	logic [CES_N_CHIP-1:0] CHIP_REQ;
	logic [4*CES_N_CHIP-1:0] CHIP_LEVEL;
	logic [64:0] log_q [3];
	int err_total, total_checks, cyc, i;
	ces_sequencer dut (.*);
	ces_mem_model mem (.*);
	// Free running clock.
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	// Hang guard.
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	// Compares one value and counts the outcome.
	task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Presents one decoded instruction for a single cycle.
	task automatic decode(input ces_op_t op, input logic [31:0] pc);
		@(negedge CLOCK);
		DEC_VALID = 1'b1;
		DEC_OP = op;
		DEC_PC = pc;
		DEC_NEXT_PC = pc + 32'h2;
		DEC_TARGET = pc + 32'h40;
		@(negedge CLOCK);
		DEC_VALID = 1'b0;
	endtask
	// Expects that no exception is entered.
	task automatic none;
		repeat (3) begin
			@(negedge CLOCK);
			chk(EXC_BUSY, 1'b0);
		end
	endtask
	// Reports a bus fault.
	task automatic fault;
		@(negedge CLOCK);
		ADDR_ERR = 1'b1;
		@(negedge CLOCK);
		ADDR_ERR = 1'b0;
	endtask
	// Follows one exception entry and checks pushes, vector read and core updates.
	task automatic expect_exc(input logic [7:0] vec, input logic [31:0] spc, input logic mld,
			input logic [3:0] mval, input logic ack, input logic [5:0] idx);
		logic up, ak, ml;
		logic [5:0] ai;
		logic [3:0] mv;
		logic [31:0] pcv, va;
		int sl;
		va = BASE_INIT + {22'h0, vec, 2'h0};
		sl = 0;
		up = 1'b0;
		ak = 1'b0;
		ml = 1'b0;
		ai = 6'h3F;
		mv = 4'h0;
		pcv = 32'h0;
		for (int n = 0; n < 200; n++) begin
			if (INT_ACK === 1'b1) begin
				ak = 1'b1;
				ai = INT_ACK_INDEX;
				NMI_REQ = 1'b0;
				BRK_REQ = 1'b0;
				EXT_REQ = 8'h00;
				CHIP_REQ = '0;
			end
			if (MASK_LOAD === 1'b1) begin
				ml = 1'b1;
				mv = MASK_VALUE;
			end
			if (PC_LOAD === 1'b1) pcv = PC_VALUE;
			if (SP_LOAD === 1'b1) sl++;
			if (EXC_BUSY === 1'b1) begin
				up = 1'b1;
			end else if (up) begin
				break;
			end
			@(negedge CLOCK);
		end
		chk(up, 1'b1);
		chk(ak, ack);
		if (ack) chk(ai, idx);
		chk(ml, mld);
		if (mld) chk(mv, mval);
		chk(log_q[0], {1'b1, SP - 32'h4, STATUS_INIT});
		chk(sl, 2);
		chk(log_q[1], {1'b1, SP - 32'h8, spc});
		chk(log_q[2], {1'b0, va, 32'h0});
		chk(pcv, va ^ 32'hA5A5_0000);
		chk(SP_VALUE, SP - 32'h8);
	endtask
	// Interrupt acceptance, masking and arbitration, with a slow bus.
	task automatic t_int;
		wait_cycles = 4'h3;
		STATUS_MASK = 4'h4;
		EXT_LEVEL = 32'h0000_0500;
		EXT_REQ = 8'h04;
		decode(CES_OP_OTHER, 32'h200);
		expect_exc(8'h42, 32'h200, 1'b1, 4'h5, 1'b1, 6'h04);
		EXT_LEVEL = 32'h0000_0400;
		EXT_REQ = 8'h04;
		decode(CES_OP_OTHER, 32'h210);
		none();
		EXT_REQ = 8'h00;
		STATUS_MASK = 4'hF;
		NMI_REQ = 1'b1;
		decode(CES_OP_OTHER, 32'h220);
		expect_exc(CES_VEC_NMI, 32'h220, 1'b1, 4'hF, 1'b1, CES_IDX_NMI);
		STATUS_MASK = 4'hE;
		BRK_REQ = 1'b1;
		decode(CES_OP_OTHER, 32'h230);
		expect_exc(CES_VEC_BRK, 32'h230, 1'b1, 4'hF, 1'b1, CES_IDX_BRK);
		STATUS_MASK = 4'h0;
		EXT_LEVEL = 32'h0000_0005;
		EXT_REQ = 8'h01;
		CHIP_LEVEL = 120'h0_C000;
		CHIP_REQ = 30'h0000_0008;
		decode(CES_OP_OTHER, 32'h240);
		expect_exc(8'h4B, 32'h240, 1'b1, 4'hC, 1'b1, 6'h0D);
		wait_cycles = 4'h0;
		$display("end of interrupt test, mismatches %0d", err_total);
	endtask
	// Trap, general illegal and every slot case.
	task automatic t_instr;
		DEC_TRAP_VEC = 8'h21;
		decode(CES_OP_SOFTWARE_TRAP, 32'h300);
		expect_exc(8'h21, 32'h302, 1'b0, 4'h0, 1'b0, 6'h00);
		decode(CES_OP_UNDEFINED, 32'h310);
		expect_exc(8'h04, 32'h310, 1'b0, 4'h0, 1'b0, 6'h00);
		for (i = 0; i < 10; i++) begin
			decode(ces_op_t'(4'(1 + i % 6)), 32'h400 + 32'(i * 16));
			decode((i == 9) ? CES_OP_UNDEFINED : ces_op_t'(4'(i + 1)), 32'h402 + 32'(i * 16));
			expect_exc(8'h06, 32'h440 + 32'(i * 16), 1'b0, 4'h0, 1'b0, 6'h00);
		end
		$display("end of instruction test, mismatches %0d", err_total);
	endtask
	// Address error held by the bus, execution and a slot, then ahead of an interrupt.
	task automatic t_addr;
		BUS_BUSY = 1'b1;
		EXEC_BUSY = 1'b1;
		fault();
		decode(CES_OP_OTHER, 32'h500);
		none();
		BUS_BUSY = 1'b0;
		decode(CES_OP_RELATIVE_BRANCH, 32'h502);
		none();
		EXEC_BUSY = 1'b0;
		EXT_LEVEL = 32'h0000_0005;
		EXT_REQ = 8'h01;
		decode(CES_OP_OTHER, 32'h504);
		none();
		decode(CES_OP_OTHER, 32'h508);
		expect_exc(8'h09, 32'h508, 1'b0, 4'h0, 1'b0, 6'h00);
		decode(CES_OP_OTHER, 32'h50A);
		expect_exc(8'h40, 32'h50A, 1'b1, 4'h5, 1'b1, 6'h02);
		$display("end of address error test, mismatches %0d", err_total);
	endtask
	// Control register moves hold interrupts but not address errors.
	task automatic t_hold;
		decode(CES_OP_CONTROL_LDST, 32'h600);
		EXT_REQ = 8'h01;
		decode(CES_OP_OTHER, 32'h602);
		none();
		decode(CES_OP_OTHER, 32'h604);
		expect_exc(8'h40, 32'h604, 1'b1, 4'h5, 1'b1, 6'h02);
		decode(CES_OP_CONTROL_LDST, 32'h610);
		fault();
		decode(CES_OP_OTHER, 32'h612);
		expect_exc(8'h09, 32'h612, 1'b0, 4'h0, 1'b0, 6'h00);
		$display("end of hold test, mismatches %0d", err_total);
	endtask
	// Main sequence.
	initial begin
		RESET = 1'b1;
		{DEC_VALID, ADDR_ERR, BUS_BUSY, EXEC_BUSY, NMI_REQ, BRK_REQ} = '0;
		DEC_OP = CES_OP_OTHER;
		{DEC_PC, DEC_NEXT_PC, DEC_TARGET, EXT_LEVEL} = '0;
		{DEC_TRAP_VEC, EXT_REQ, STATUS_MASK, wait_cycles} = '0;
		CHIP_REQ = '0;
		CHIP_LEVEL = '0;
		STATUS_WORD = STATUS_INIT;
		STACK_PTR = SP;
		VECTOR_BASE = BASE_INIT;
		repeat (10) @(posedge CLOCK);
		@(negedge CLOCK);
		RESET = 1'b0;
		t_int();
		t_instr();
		t_addr();
		t_hold();
		final_report();
	end
endmodule
`default_nettype wire
